// File: fbe_pkg.sv
/*
 fbe_pkg: shared constants for the frame buffer empty indicator link,
 the device end and the controller end.
 assumes both ends run on pclk at the rate named below.
*/
`default_nettype none
package fbe_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int IND_VALID_DELAY_NS = 750;
    // longest time, rounded down
    localparam int IND_VALID_DELAY_CYC = IND_VALID_DELAY_NS / CLK_PERIOD_NS;
    localparam int OCTET_PERIOD_NS = 32000;
    localparam int OCTETS_TIMEOUT = 2;
    localparam int DEF_TIMEOUT_CYC =
        (OCTETS_TIMEOUT * OCTET_PERIOD_NS) / CLK_PERIOD_NS;
    localparam logic [7:0] SCLK_HALF_CYC = 8'h14;
    // register map of the device, reached over the link
    localparam logic [5:0] TRX_CTRL_ONE_ADDR = 6'h04;
    localparam logic [7:0] TRX_CTRL_ONE_RST = 8'h22;
    localparam int BUF_EMPTY_EN_BIT = 4;
    localparam int IRQ_POL_BIT = 0;
    // link command bytes
    localparam logic [7:0] CMD_FB_READ = 8'h20;
    localparam logic [1:0] CMD_REG_RD_TAG = 2'h2;
    localparam logic [1:0] CMD_REG_WR_TAG = 2'h3;
    // frame store
    localparam logic [7:0] FB_DEPTH = 8'h80;
    localparam logic [7:0] TRAILER_LQI = 8'h00;
    localparam logic [7:0] TRAILER_ED = 8'h01;
    localparam logic [7:0] TRAILER_STATUS = 8'h02;
    // controller register offsets
    localparam logic [11:0] HOST_CMD_OFS = 12'h000;
    localparam logic [11:0] HOST_RX_OFS = 12'h004;
    localparam logic [11:0] HOST_STAT_OFS = 12'h008;
    typedef enum logic [1:0] {
        FBE_OP_NONE = 2'b00,
        FBE_OP_RD = 2'b01,
        FBE_OP_WR = 2'b10,
        FBE_OP_FB = 2'b11
    } fbe_op_t;
    function automatic fbe_op_t fbe_decode(input logic [7:0] cmd);
        fbe_op_t op;
        op = FBE_OP_NONE;
        if (cmd == CMD_FB_READ) begin
            op = FBE_OP_FB;
        end else if (cmd[7:6] == CMD_REG_WR_TAG) begin
            op = FBE_OP_WR;
        end else if (cmd[7:6] == CMD_REG_RD_TAG) begin
            op = FBE_OP_RD;
        end
        return op;
    endfunction
endpackage
`default_nettype wire

// File: fbe_if.sv
/*
 fbe_if: the serial link between controller and device, with the
 shared interrupt / buffer empty pin.
 assumes the bench joins both modports; no clock travels with it.
*/
`timescale 1ns/100ps
`default_nettype none
interface fbe_if;
    logic sclk;
    logic sel_n;
    logic mosi;
    logic miso;
    logic irq;
    modport dev (input sclk, input sel_n, input mosi, output miso,
        output irq);
    modport host (output sclk, output sel_n, output mosi, input miso,
        input irq);
endinterface // fbe_if
`default_nettype wire

// File: fbe_dev.sv
/* fbe_dev: device end; control register, frame store, input buffer,
 link slave and the empty indicator on the irq pin.
 assumes link pins come from another domain, stream and events on pclk.
*/
// Decided for this implementation: register access over the serial link.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - control bit 4 enables indicator, reset off
// - indicator from read command until select high
// - indicator valid within 750 ns of command
// - pin high while next byte not received
// - low means data available, host continues
// - high means host pauses until low
// - pin low once new data arrives
// - host watches pin during whole read
// - three trailer bytes follow PHR and PSDU
// - trailer bytes never stall the indicator
// - no interrupts shown while indicator active
// - select high restores normal interrupt role
// - receive error locks indicator high
// - host aborts after two octets without data
// - polarity setting does not touch indicator
module fbe_dev import fbe_pkg::*; (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // link
    fbe_if.dev link,
    // receive stream
    input wire logic rx_start,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // receive events and trailer values
    input wire logic rx_error,
    input wire logic irq_pending,
    input wire logic [7:0] lqi,
    input wire logic [7:0] ed,
    input wire logic [7:0] rx_status,
    // status
    output logic fb_active,
    output logic [7:0] ctrl_value
);
    logic sclk_m_ff, sclk_ff, sclk_d_ff;
    logic sel_m_ff, sel_ff, mosi_m_ff, mosi_ff;
    logic [2:0] bit_ff;
    logic [7:0] rxsh_ff;
    logic [1:0] byte_no_ff;
    fbe_op_t op_ff;
    logic [5:0] addr_ff;
    logic [7:0] ctrl_ff;
    logic fb_act_ff;
    logic err_ff;
    logic need_ff;
    logic [7:0] tx_ff, rd_idx_ff, wr_cnt_ff, buf0_ff, buf1_ff;
    logic irq_ff;
    logic [1:0] cnt_ff;
    logic [7:0] mem [0:127];
    logic rise, fall, sel_on, byte_done;
    logic [7:0] rx_byte, total, trail_idx, next_byte;
    logic empty_data, load_now, push, drain, nxt_irq, fb_go;
    assign rise = sclk_ff & ~sclk_d_ff;
    assign fall = ~sclk_ff & sclk_d_ff;
    assign sel_on = ~sel_ff;
    assign byte_done = rise & sel_on & (bit_ff == 3'h7);
    assign rx_byte = {rxsh_ff[6:0], mosi_ff};
    // header byte plus PSDU; trailer bytes are not in the store
    assign total = {1'b0, mem[0][6:0]} + 8'h01;
    assign trail_idx = rd_idx_ff - total;
    assign empty_data = (rd_idx_ff >= wr_cnt_ff) &
        ((wr_cnt_ff == 8'h00) | (rd_idx_ff < total));
    // stall only a frame read with the indicator switched on
    assign load_now = need_ff & ~sclk_ff & sel_on &
        ~(fb_act_ff & (err_ff | empty_data));
    assign fb_go = byte_done & (byte_no_ff == 2'h0) &
        (fbe_decode(rx_byte) == FBE_OP_FB) & ctrl_ff[BUF_EMPTY_EN_BIT];
    assign push = rx_valid & rx_ready;
    assign drain = (cnt_ff != 2'h0) & (wr_cnt_ff < FB_DEPTH);
    assign rx_ready = (cnt_ff != 2'h2);
    assign fb_active = fb_act_ff;
    assign ctrl_value = ctrl_ff;
    assign link.miso = tx_ff[7];
    assign link.irq = irq_ff;
    always_comb begin
        next_byte = 8'h00;
        case (op_ff)
            FBE_OP_RD: begin
                if (addr_ff == TRX_CTRL_ONE_ADDR) begin
                    next_byte = ctrl_ff;
                end
            end
            FBE_OP_FB: begin
                if (rd_idx_ff < total) begin
                    next_byte = mem[rd_idx_ff[6:0]];
                end else if (trail_idx == TRAILER_LQI) begin
                    next_byte = lqi;
                end else if (trail_idx == TRAILER_ED) begin
                    next_byte = ed;
                end else if (trail_idx == TRAILER_STATUS) begin
                    next_byte = rx_status;
                end
            end
            default: begin
                next_byte = 8'h00;
            end
        endcase
    end
    // two flops on every pin before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_m_ff <= 1'b0;
            sclk_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
            sel_m_ff <= 1'b1;
            sel_ff <= 1'b1;
            mosi_m_ff <= 1'b0;
            mosi_ff <= 1'b0;
        end else if (ce) begin
            sclk_m_ff <= link.sclk;
            sclk_ff <= sclk_m_ff;
            sclk_d_ff <= sclk_ff;
            sel_m_ff <= link.sel_n;
            sel_ff <= sel_m_ff;
            mosi_m_ff <= link.mosi;
            mosi_ff <= mosi_m_ff;
        end
    end
    // byte framing and command decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_ff <= 3'h0;
            rxsh_ff <= 8'h00;
            byte_no_ff <= 2'h0;
            op_ff <= FBE_OP_NONE;
            addr_ff <= 6'h00;
        end else if (ce) begin
            if (!sel_on) begin
                bit_ff <= 3'h0;
                byte_no_ff <= 2'h0;
                op_ff <= FBE_OP_NONE;
            end else if (rise) begin
                bit_ff <= bit_ff + 3'h1;
                rxsh_ff <= rx_byte;
                if (byte_done && byte_no_ff == 2'h0) begin
                    op_ff <= fbe_decode(rx_byte);
                    addr_ff <= rx_byte[5:0];
                end
                if (byte_done && byte_no_ff != 2'h3) begin
                    byte_no_ff <= byte_no_ff + 2'h1;
                end
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= TRX_CTRL_ONE_RST;
        end else if (ce) begin
            if (byte_done && byte_no_ff == 2'h1 && op_ff == FBE_OP_WR &&
                    addr_ff == TRX_CTRL_ONE_ADDR) begin
                ctrl_ff <= rx_byte;
            end
        end
    end
    // indicator window: command byte end until select high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_act_ff <= 1'b0;
        end else if (ce) begin
            if (!sel_on) begin
                fb_act_ff <= 1'b0;
            end else if (byte_done && byte_no_ff == 2'h0 &&
                    fbe_decode(rx_byte) == FBE_OP_FB) begin
                fb_act_ff <= ctrl_ff[BUF_EMPTY_EN_BIT];
            end
        end
    end
    // error lock; a set in the clearing cycle wins, the clear follows a cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= 1'b0;
        end else if (ce) begin
            if (rx_error && fb_act_ff) begin
                err_ff <= 1'b1;
            end else if (!sel_on) begin
                err_ff <= 1'b0;
            end
        end
    end
    // miso shifting; next byte held back while the store is short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            need_ff <= 1'b0;
            tx_ff <= 8'h00;
            rd_idx_ff <= 8'h00;
        end else if (ce) begin
            if (!sel_on) begin
                need_ff <= 1'b0;
                tx_ff <= {7'h00, irq_pending};
                rd_idx_ff <= 8'h00;
            end else if (byte_done) begin
                need_ff <= 1'b1;
            end else if (load_now) begin
                need_ff <= 1'b0;
                tx_ff <= next_byte;
                if (op_ff == FBE_OP_FB) begin
                    rd_idx_ff <= rd_idx_ff + 8'h01;
                end
            end else if (fall && !need_ff) begin
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end
    // registered so the pin never glitches; the role turns with the
    // command byte so no stale request leaks in its first cycle
    assign nxt_irq = (fb_act_ff | fb_go) ?
        (err_ff | (need_ff & empty_data)) :
        (irq_pending ^ ctrl_ff[IRQ_POL_BIT]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= nxt_irq;
        end
    end
    // two-entry input buffer; stalls when the store is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf0_ff <= 8'h00;
            buf1_ff <= 8'h00;
            cnt_ff <= 2'h0;
        end else if (ce) begin
            if (push && drain) begin
                if (cnt_ff == 2'h1) begin
                    buf0_ff <= rx_data;
                end else begin
                    buf0_ff <= buf1_ff;
                    buf1_ff <= rx_data;
                end
            end else if (push) begin
                cnt_ff <= cnt_ff + 2'h1;
                if (cnt_ff == 2'h0) begin
                    buf0_ff <= rx_data;
                end else begin
                    buf1_ff <= rx_data;
                end
            end else if (drain) begin
                cnt_ff <= cnt_ff - 2'h1;
                buf0_ff <= buf1_ff;
            end
        end
    end
    // new frame restarts the store only outside the indicator window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_cnt_ff <= 8'h00;
        end else if (ce) begin
            if (rx_start && !fb_act_ff) begin
                wr_cnt_ff <= 8'h00;
            end else if (drain) begin
                wr_cnt_ff <= wr_cnt_ff + 8'h01;
            end
        end
    end
    always_ff @(posedge pclk) begin
        if (ce && drain && !(rx_start && !fb_act_ff)) begin
            mem[wr_cnt_ff[6:0]] <= buf0_ff;
        end
    end
endmodule // fbe_dev
`default_nettype wire

// File: fbe_host.sv
/*
 fbe_host: controller end; APB slave with command, receive and
 status registers, drives the link and gates frame reads on irq.
 assumes irq and miso come from another domain.
*/
`timescale 1ns/100ps
`default_nettype none
module fbe_host import fbe_pkg::*; #(
    parameter int TIMEOUT_CYC = DEF_TIMEOUT_CYC
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link
    fbe_if.host link
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SEL = 3'b001,
        H_BIT = 3'b010,
        H_WAIT = 3'b011,
        H_END = 3'b100
    } fbe_hst_t;
    fbe_hst_t st_ff;
    logic [7:0] div_ff, left_ff, tx_ff, rxsh_ff, wdat_ff, rxd_ff;
    logic [2:0] bit_ff;
    logic sclk_ff, sel_n_ff, fb_ff, first_ff;
    logic rx_full_ff, tmo_flag_ff;
    logic [15:0] tmo_ff;
    logic irq_m_ff, irq_s_ff, miso_m_ff, miso_s_ff;
    logic [31:0] prdata_ff;
    logic acc, wr_cmd, rd_rx, mapped, half_up, wait_up, go_on;
    logic [7:0] wait_cyc;

    assign acc = psel & penable;
    assign mapped = (paddr == HOST_CMD_OFS) | (paddr == HOST_RX_OFS) |
        (paddr == HOST_STAT_OFS);
    assign wr_cmd = acc & pwrite & (paddr == HOST_CMD_OFS);
    assign rd_rx = acc & ~pwrite & (paddr == HOST_RX_OFS);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_ff;
    assign link.sclk = sclk_ff;
    assign link.sel_n = sel_n_ff;
    assign link.mosi = tx_ff[7];
    assign half_up = (div_ff == SCLK_HALF_CYC - 8'h01);
    assign wait_cyc = fb_ff ? 8'(IND_VALID_DELAY_CYC) : SCLK_HALF_CYC;
    assign wait_up = (div_ff >= wait_cyc);
    // on a frame read, next byte only while the pin says data is there
    assign go_on = ~rx_full_ff & ~(fb_ff & irq_s_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_m_ff <= 1'b0;
            irq_s_ff <= 1'b0;
            miso_m_ff <= 1'b0;
            miso_s_ff <= 1'b0;
        end else if (ce) begin
            irq_m_ff <= link.irq;
            irq_s_ff <= irq_m_ff;
            miso_m_ff <= link.miso;
            miso_s_ff <= miso_m_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (ce && psel && !penable) begin
            prdata_ff <= 32'h00000000;
            if (paddr == HOST_RX_OFS) begin
                prdata_ff <= {24'h000000, rxd_ff};
            end else if (paddr == HOST_STAT_OFS) begin
                prdata_ff <= {28'h0000000, irq_s_ff, tmo_flag_ff,
                    rx_full_ff, (st_ff != H_IDLE)};
            end
        end
    end

    // byte waiting for software; set wins over the read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_ff <= 1'b0;
            rxd_ff <= 8'h00;
        end else if (ce) begin
            if (st_ff == H_BIT && half_up && sclk_ff && bit_ff == 3'h7 &&
                    !first_ff) begin
                rx_full_ff <= 1'b1;
                rxd_ff <= rxsh_ff;
            end else if (rd_rx) begin
                rx_full_ff <= 1'b0;
            end
        end
    end

    // stall watchdog on a frame read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_ff <= 16'h0000;
            tmo_flag_ff <= 1'b0;
        end else if (ce) begin
            if (wr_cmd && st_ff == H_IDLE) begin
                tmo_flag_ff <= 1'b0;
            end else if (st_ff == H_WAIT && fb_ff && irq_s_ff &&
                    tmo_ff == 16'(TIMEOUT_CYC - 1)) begin
                tmo_flag_ff <= 1'b1;
            end
            if (st_ff == H_WAIT && fb_ff && irq_s_ff) begin
                tmo_ff <= tmo_ff + 16'h0001;
            end else begin
                tmo_ff <= 16'h0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= H_IDLE;
            div_ff <= 8'h00;
            left_ff <= 8'h00;
            tx_ff <= 8'h00;
            rxsh_ff <= 8'h00;
            wdat_ff <= 8'h00;
            bit_ff <= 3'h0;
            sclk_ff <= 1'b0;
            sel_n_ff <= 1'b1;
            fb_ff <= 1'b0;
            first_ff <= 1'b0;
        end else if (ce) begin
            div_ff <= div_ff + 8'h01;
            case (st_ff)
                H_IDLE: begin
                    if (wr_cmd) begin
                        tx_ff <= pwdata[7:0];
                        wdat_ff <= pwdata[15:8];
                        left_ff <= pwdata[23:16];
                        fb_ff <= (fbe_decode(pwdata[7:0]) == FBE_OP_FB);
                        first_ff <= 1'b1;
                        sel_n_ff <= 1'b0;
                        div_ff <= 8'h00;
                        st_ff <= H_SEL;
                    end
                end
                H_SEL: begin
                    if (half_up) begin
                        div_ff <= 8'h00;
                        bit_ff <= 3'h0;
                        st_ff <= H_BIT;
                    end
                end
                H_BIT: begin
                    if (half_up) begin
                        div_ff <= 8'h00;
                        sclk_ff <= ~sclk_ff;
                        if (!sclk_ff) begin
                            rxsh_ff <= {rxsh_ff[6:0], miso_s_ff};
                        end else if (bit_ff != 3'h7) begin
                            bit_ff <= bit_ff + 3'h1;
                            tx_ff <= {tx_ff[6:0], 1'b0};
                        end else begin
                            first_ff <= 1'b0;
                            left_ff <= left_ff - 8'h01;
                            tx_ff <= fb_ff ? 8'h00 : wdat_ff;
                            st_ff <= (left_ff == 8'h00) ? H_END : H_WAIT;
                        end
                    end
                end
                H_WAIT: begin
                    if (tmo_flag_ff) begin
                        div_ff <= 8'h00;
                        st_ff <= H_END;
                    end else if (wait_up && go_on) begin
                        div_ff <= 8'h00;
                        bit_ff <= 3'h0;
                        st_ff <= H_BIT;
                    end else if (wait_up) begin
                        div_ff <= wait_cyc;
                    end
                end
                H_END: begin
                    sel_n_ff <= 1'b1;
                    if (half_up) begin
                        st_ff <= H_IDLE;
                    end
                end
                default: begin
                    st_ff <= H_IDLE;
                end
            endcase
        end
    end
endmodule // fbe_host
`default_nettype wire

// File: fbe_props.sv
/*
 fbe_props: link checks beside the fbe_if that joins both ends.
 assumes every signal is on pclk and presetn is async, active low.
*/
`timescale 1ns/100ps
`default_nettype none
module fbe_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link pins
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic irq,
    // device side
    input wire logic fb_active,
    input wire logic irq_pending,
    input wire logic [7:0] ctrl_value
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sclk_idle_a: assert property (sel_n |-> !sclk)
        else $error("sclk moves while deselected");
    mosi_edge_a: assert property (!sel_n && $changed(mosi) |-> !sclk)
        else $error("mosi changed with sclk high");
    miso_edge_a: assert property (!sel_n && $changed(miso) |-> !sclk)
        else $error("miso changed with sclk high");
    sclk_half_a: assert property ($rose(sclk) |-> sclk [*8])
        else $error("sclk high phase too short");
    host_pause_a: assert property (fb_active && irq [*8] |-> !$rose(sclk))
        else $error("host clocked while buffer empty");
    act_start_a: assert property ($rose(fb_active) |-> !sel_n)
        else $error("indicator role without select");
    act_end_a: assert property ($rose(sel_n) |-> ##[1:6] !fb_active)
        else $error("indicator role outlived select");
    // registered pin, so the normal role shows one cycle late
    irq_role_a: assert property (
        !fb_active && $past(!fb_active) && $past(presetn)
        |-> irq == $past(irq_pending ^ ctrl_value[0]))
        else $error("irq does not follow pending request");
    cover property ($rose(fb_active));
    cover property (fb_active && irq [*8]);
    cover property ($rose(sel_n));
endmodule // fbe_props
`default_nettype wire

// File: frame_buffer_empty_indicator_test.sv
/*
 frame_buffer_empty_indicator_test: both link ends, apb and rx stream
 from the bench, byte queue model compared after each completed read.
 assumes fbe_pkg, fbe_if, fbe_dev, fbe_host, fbe_props compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module frame_buffer_empty_indicator_test import fbe_pkg::*;;
    logic pclk = 1'b0;
    logic presetn;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, st;
    logic pready, pslverr, rx_ready, fb_active, perr;
    logic rx_start = 1'b0;
    logic rx_valid = 1'b0;
    logic rx_error = 1'b0;
    logic irq_pending = 1'b0;
    logic irq_hi = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic [7:0] lqi = 8'h00;
    logic [7:0] ed = 8'h00;
    logic [7:0] rx_status = 8'h00;
    logic [7:0] ctrl_value;
    logic [7:0] fr[$], exp_q[$], got_q[$];
    int seed = 43559;
    int fail_count = 0;
    int checked = 0;
    fbe_if link ();
    fbe_dev i_fbe_dev (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .link(link.dev), .rx_start(rx_start), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .rx_error(rx_error),
        .irq_pending(irq_pending), .lqi(lqi), .ed(ed),
        .rx_status(rx_status), .fb_active(fb_active),
        .ctrl_value(ctrl_value));
    // short timeout so the error lock shows within the run
    fbe_host #(.TIMEOUT_CYC(400)) i_fbe_host (.pclk(pclk),
        .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    fbe_props i_fbe_props (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .sel_n(link.sel_n), .mosi(link.mosi),
        .miso(link.miso), .irq(link.irq), .fb_active(fb_active),
        .irq_pending(irq_pending), .ctrl_value(ctrl_value));
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (presetn) irq_pending <= 1'($random(seed));
        if (fb_active === 1'b1 && link.irq === 1'b1) irq_hi <= 1'b1;
    end
    task automatic final_report;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // a command written while busy is dropped, so wait for idle after
    task automatic xfer(input logic [7:0] c, input logic [7:0] d,
        input int n);
        got_q.delete();
        apb(1'b1, HOST_CMD_OFS, {8'h00, 8'(n), d, c}, st);
        repeat (n) begin
            do apb(1'b0, HOST_STAT_OFS, 32'h0, st); while (st[2:1] == 0);
            if (st[2]) break;
            apb(1'b0, HOST_RX_OFS, 32'h0, st);
            got_q.push_back(st[7:0]);
        end
        do apb(1'b0, HOST_STAT_OFS, 32'h0, st); while (st[0]);
    endtask
    task automatic cmpq;
        chk(8'(got_q.size()), 8'(exp_q.size()));
        foreach (got_q[k]) chk(got_q[k], exp_q[k]);
    endtask
    task automatic mkframe(input int n);
        logic [7:0] t0, t1, t2;
        t0 = 8'($random(seed));
        t1 = 8'($random(seed));
        t2 = 8'($random(seed));
        fr = {8'(n)};
        repeat (n) fr.push_back(8'($random(seed)));
        exp_q = {fr, t0, t1, t2};
        lqi <= t0;
        ed <= t1;
        rx_status <= t2;
        rx_start <= 1'b1;
        @(posedge pclk);
        rx_start <= 1'b0;
    endtask
    task automatic send(input int a, input int b);
        for (int k = a; k < b; k++) begin
            rx_valid <= 1'b1;
            rx_data <= fr[k];
            do @(posedge pclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
    endtask
    // stall kept under the host timeout unless the lock holds the pin
    task automatic stall(input logic err);
        do @(posedge pclk); while (!(fb_active && link.irq));
        rx_error <= err;
        @(posedge pclk);
        rx_error <= 1'b0;
        repeat (300) @(posedge pclk);
        send(1, fr.size());
    endtask
    initial begin
        // x to 0 gives the async reset its edge; an initialiser would not
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(ctrl_value, TRX_CTRL_ONE_RST);
        apb(1'b0, 12'h0FC, 32'h0, st);
        chk({7'h00, perr}, 8'h01);
        chk(st[7:0], 8'h00);
        exp_q = {TRX_CTRL_ONE_RST};
        xfer({CMD_REG_RD_TAG, TRX_CTRL_ONE_ADDR}, 8'h00, 1);
        cmpq;
        xfer({CMD_REG_WR_TAG, TRX_CTRL_ONE_ADDR}, 8'h33, 1);
        chk(ctrl_value, 8'h33);
        mkframe(3);
        send(0, 4);
        irq_hi = 1'b0;
        xfer(CMD_FB_READ, 8'h00, 7);
        cmpq;
        chk({7'h00, irq_hi}, 8'h00);
        mkframe(2);
        send(0, 1);
        irq_hi = 1'b0;
        fork
            xfer(CMD_FB_READ, 8'h00, 6);
            stall(1'b0);
        join
        cmpq;
        chk({7'h00, irq_hi}, 8'h01);
        mkframe(2);
        send(0, 1);
        fork
            xfer(CMD_FB_READ, 8'h00, 3);
            stall(1'b1);
        join
        chk({7'h00, st[2]}, 8'h01);
        final_report;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        final_report;
    end
endmodule // frame_buffer_empty_indicator_test
`default_nettype wire
